// >>> rtl/pswin_bridge.sv
// Purpose: Redirects upper-half data reads to a selectable program memory page.
// Assumes: Program memory answers in the same cycle as o_prog_req (async read).
// Notes: A request is taken only while o_ready is high; the core holds off otherwise.
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - Upper 32 Kbyte data half can map onto any 32K-word program page.
// - Redirect only when address top bit is one and window enable is set.
// - Page select is 8 bits wide, choosing one of 256 pages.
// - Program address is page select above the 15 low address bits.
// - Low 15 data address bits map one to one onto program address bits.
// - A windowed read outside repeat loops or at a repeat edge stalls the instruction for extra fetch cycles.
// - Only the low 16 bits of the 24-bit program word are returned.
// - Redirection is suspended while a table read or write runs.
// - Outside repeat loops move and double move add one cycle.
// - Outside repeat loops all other instructions add two cycles.
// - In repeat loops first, last, interrupt exit and re-entry add two cycles.
// - Other repeat iterations access the window with no added cycle.
module pswin_bridge (
  input wire logic i_sys_clk,
  input wire logic i_sys_rst,
  input wire logic i_data_req,
  input wire logic [pswin_pkg::ADDR_W-1:0] i_effective_address,
  input wire logic i_program_space_window_en,
  input wire logic [pswin_pkg::PAGE_W-1:0] i_window_page_select,
  input wire logic i_table_busy,
  input wire logic i_move_instr,
  input wire logic i_in_repeat,
  input wire logic i_rpt_first,
  input wire logic i_rpt_last,
  input wire logic i_rpt_irq_exit,
  input wire logic i_rpt_irq_reentry,
  input wire logic [pswin_pkg::WORD_W-1:0] i_prog_word,
  output logic o_ready,
  output logic o_stall,
  output logic o_ram_req,
  output logic [pswin_pkg::ADDR_W-1:0] o_ram_addr,
  output logic o_prog_req,
  output logic [pswin_pkg::PROG_ADDR_W-1:0] o_prog_addr,
  output logic o_rd_valid,
  output logic [pswin_pkg::DATA_W-1:0] o_rd_data
);
  import pswin_pkg::*;

  // ==========================================================
  // Decode
  logic take;
  logic windowed;
  logic rpt_edge;
  logic [CNT_W-1:0] extra;
  logic [CNT_W-1:0] cnt;

  assign take = i_data_req && o_ready;
  // Table transfers own the program bus, so the window steps aside for them.
  assign windowed = i_effective_address[WIN_SEL_BIT] && i_program_space_window_en
                    && !i_table_busy;
  assign rpt_edge = i_rpt_first || i_rpt_last || i_rpt_irq_exit || i_rpt_irq_reentry;

  always_comb begin
    if (i_in_repeat) begin
      extra = rpt_edge ? STALL_RPT_EDGE : STALL_RPT_MID;
    end else begin
      extra = i_move_instr ? STALL_MOVE : STALL_OTHER;
    end
  end

  pswin_stall_counter #(
    .WIDTH(CNT_W)
  ) u_stall (
    .i_sys_clk(i_sys_clk),
    .i_sys_rst(i_sys_rst),
    .i_load(take && windowed),
    .i_load_value(extra),
    .o_count(cnt)
  );

  // ==========================================================
  // Sequencer
  pswin_state_type state;
  pswin_state_type next_state;
  logic ram_req;
  logic next_ram_req;
  logic [ADDR_W-1:0] ram_addr;
  logic [ADDR_W-1:0] next_ram_addr;
  logic [PROG_ADDR_W-1:0] prog_addr;
  logic [PROG_ADDR_W-1:0] next_prog_addr;
  logic rd_valid;
  logic next_rd_valid;
  logic [DATA_W-1:0] rd_data;
  logic [DATA_W-1:0] next_rd_data;

  always_comb begin
    next_state = state;
    next_ram_req = 1'b0;
    next_ram_addr = ram_addr;
    next_prog_addr = prog_addr;
    next_rd_valid = 1'b0;
    next_rd_data = rd_data;
    case (state)
      ST_IDLE: begin
        if (take && windowed) begin
          next_prog_addr = {i_window_page_select, i_effective_address[OFFS_W-1:0]};
          next_state = ST_FETCH;
        end else if (take) begin
          next_ram_req = 1'b1;
          next_ram_addr = i_effective_address;
        end
      end
      ST_FETCH: begin
        next_rd_data = i_prog_word[DATA_W-1:0];
        if (cnt == STALL_NONE) begin
          next_rd_valid = 1'b1;
          next_state = ST_IDLE;
        end else begin
          next_state = ST_WAIT;
        end
      end
      ST_WAIT: begin
        if (cnt == STALL_NONE) begin
          next_rd_valid = 1'b1;
          next_state = ST_IDLE;
        end
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      state <= ST_IDLE;
      ram_req <= 1'b0;
      ram_addr <= RAM_ADDR_RST;
      prog_addr <= PROG_ADDR_RST;
      rd_valid <= 1'b0;
      rd_data <= DATA_RST;
    end else begin
      state <= next_state;
      ram_req <= next_ram_req;
      ram_addr <= next_ram_addr;
      prog_addr <= next_prog_addr;
      rd_valid <= next_rd_valid;
      rd_data <= next_rd_data;
    end
  end

  assign o_ready = (state == ST_IDLE);
  // The stall tracks the counter, so plain data accesses never see it.
  assign o_stall = (cnt != STALL_NONE);
  assign o_ram_req = ram_req;
  assign o_ram_addr = ram_addr;
  assign o_prog_req = (state == ST_FETCH);
  assign o_prog_addr = prog_addr;
  assign o_rd_valid = rd_valid;
  assign o_rd_data = rd_data;

  // ==========================================================
  // Checks
  a_ram_no_stall: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
    take && !windowed |=> o_ram_req && !o_stall && !o_prog_req)
    else $error("plain data access stalled or missed data memory");

  a_table_suspends: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
    take && i_effective_address[WIN_SEL_BIT] && i_program_space_window_en && i_table_busy
    |=> o_ram_req && !o_prog_req)
    else $error("window redirected during table transfer");

  a_prog_addr_map: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
    take && windowed |=> o_prog_req && o_prog_addr ==
    {$past(i_window_page_select), $past(i_effective_address[OFFS_W-1:0])})
    else $error("program address not page over low offset");

  a_data_low_half: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
    o_prog_req |=> o_rd_data == $past(i_prog_word[DATA_W-1:0]))
    else $error("returned data is not the low half of the word");

  a_move_one_stall: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
    take && windowed && !i_in_repeat && i_move_instr
    |=> o_stall ##1 !o_stall ##1 o_rd_valid)
    else $error("move through window not exactly one extra cycle");

  a_other_two_stall: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
    take && windowed && !i_in_repeat && !i_move_instr
    |=> o_stall[*2] ##1 !o_stall && !o_rd_valid ##1 o_rd_valid)
    else $error("other instruction not exactly two extra cycles");

  a_rpt_edge_two: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
    take && windowed && i_in_repeat && rpt_edge |=> o_stall[*2] ##1 !o_stall)
    else $error("repeat edge iteration not two extra cycles");

  a_rpt_mid_single: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
    take && windowed && i_in_repeat && !rpt_edge |=> !o_stall ##1 o_rd_valid)
    else $error("middle repeat iteration stalled");

  a_busy_not_ready: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
    take && windowed |=> !o_ready)
    else $error("new request accepted during window access");

  // Ready may only come back together with the data, so no request slips in early.
  a_ready_with_data: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
    !o_ready |=> o_ready == o_rd_valid)
    else $error("ready returned without read data");

  // The longest access class adds two cycles, so four cycles bound every windowed read.
  a_window_latency: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
    take && windowed |-> ##[2:4] o_rd_valid)
    else $error("windowed read did not complete in time");

  a_fetch_pulse: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
    o_prog_req |=> !o_prog_req)
    else $error("program fetch lasted more than one cycle");

  a_valid_pulse: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
    o_rd_valid |=> !o_rd_valid)
    else $error("read valid lasted more than one cycle");

  a_stall_only_busy: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
    o_stall |-> !o_ready)
    else $error("stall raised while no window access was running");
endmodule : pswin_bridge
`default_nettype wire

// >>> rtl/pswin_pkg.sv
// Purpose: Shared constants for the program space data window.
// Assumes: 16-bit effective addresses and 24-bit program words.
// Notes: Stall figures are extra instruction cycles at the core clock.
package pswin_pkg;
  // ==========================================================
  // Widths
  localparam int ADDR_W = 16;
  localparam int PAGE_W = 8;
  localparam int OFFS_W = 15;
  localparam int PROG_ADDR_W = PAGE_W + OFFS_W;
  localparam int WORD_W = 24;
  localparam int DATA_W = 16;
  localparam int CNT_W = 2;
  // ==========================================================
  // Address decode and reset values
  localparam int WIN_SEL_BIT = 15;
  localparam logic [ADDR_W-1:0] WIN_BASE = 16'h8000;
  localparam logic [PROG_ADDR_W-1:0] PROG_ADDR_RST = 23'h000000;
  localparam logic [DATA_W-1:0] DATA_RST = 16'h0000;
  localparam logic [ADDR_W-1:0] RAM_ADDR_RST = 16'h0000;
  // ==========================================================
  // Extra cycles per access class
  localparam logic [CNT_W-1:0] STALL_NONE = 2'h0;
  localparam logic [CNT_W-1:0] STALL_MOVE = 2'h1;
  localparam logic [CNT_W-1:0] STALL_OTHER = 2'h2;
  localparam logic [CNT_W-1:0] STALL_RPT_EDGE = 2'h2;
  localparam logic [CNT_W-1:0] STALL_RPT_MID = 2'h0;
  typedef enum logic [1:0] {ST_IDLE, ST_FETCH, ST_WAIT} pswin_state_type;
endpackage : pswin_pkg

// >>> rtl/pswin_stall_counter.sv
// Purpose: Down counter that holds the remaining extra cycles of an access.
// Assumes: Loaded once per access, counts down to zero and rests there.
// Notes: Load wins over the decrement.
`timescale 1ns/1ps
`default_nettype none
module pswin_stall_counter #(
  parameter int WIDTH = 2
) (
  input wire logic i_sys_clk,
  input wire logic i_sys_rst,
  input wire logic i_load,
  input wire logic [WIDTH-1:0] i_load_value,
  output logic [WIDTH-1:0] o_count
);
  logic [WIDTH-1:0] count;
  logic [WIDTH-1:0] next_count;

  always_comb begin
    next_count = count;
    if (i_load) begin
      next_count = i_load_value;
    end else if (count != '0) begin
      next_count = count - WIDTH'(1);
    end
  end

  always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      count <= '0;
    end else begin
      count <= next_count;
    end
  end

  assign o_count = count;
endmodule : pswin_stall_counter
`default_nettype wire

// >>> verification/pswin_prog_mem_model.sv
// Purpose: Program memory stand-in for the window bridge bench.
// Assumes: Asynchronous read, word valid in the cycle of the fetch pulse.
// Notes: Between fetches the word toggles so stale data never looks valid.
`timescale 1ns/1ps
`default_nettype none
module pswin_prog_mem_model (
  input wire logic i_sys_clk,
  input wire logic i_prog_req,
  input wire logic [pswin_pkg::PROG_ADDR_W-1:0] i_prog_addr,
  output logic [pswin_pkg::WORD_W-1:0] o_prog_word
);
  import pswin_pkg::*;
  logic [WORD_W-1:0] last = 24'h000000;
  always_ff @(posedge i_sys_clk) begin
    last <= o_prog_word;
  end
  // ==========================================================
  // Read port
  // Upper byte is all ones or all zeros so the word would decode as a no-op.
  always_comb begin
    if (i_prog_req) begin
      o_prog_word = {{8{i_prog_addr[0]}}, i_prog_addr[15:0] ^ 16'hA5C3};
    end else begin
      o_prog_word = ~last;
    end
  end
endmodule : pswin_prog_mem_model
`default_nettype wire

// >>> verification/tb.sv
// Purpose: Self-checking bench for the program space window bridge.
// Assumes: Inputs change at the falling edge; outputs are read there too.
// Notes: Latency and stall counts are worked out from the access class.
`timescale 1ns/1ps
`default_nettype none
module tb;
  import pswin_pkg::*;
  logic i_sys_clk = 1'b0;
  logic i_sys_rst = 1'b1;
  logic req = 1'b0, en = 1'b0, tbusy = 1'b0, mv = 1'b0, rep = 1'b0;
  logic [3:0] fl = 4'h0;
  logic [ADDR_W-1:0] ea = 16'h0000;
  logic [PAGE_W-1:0] page = 8'h00;
  logic [WORD_W-1:0] word;
  logic ready, stall, ram_req, prog_req, rd_valid;
  logic [ADDR_W-1:0] ram_addr;
  logic [PROG_ADDR_W-1:0] prog_addr;
  logic [DATA_W-1:0] rd_data;
  logic [DATA_W-1:0] exp_q[$];
  int errors = 0, compares = 0, seed = 32'h86d8;
  pswin_bridge dut (.i_sys_clk(i_sys_clk), .i_sys_rst(i_sys_rst), .i_data_req(req),
    .i_effective_address(ea), .i_program_space_window_en(en), .i_window_page_select(page),
    .i_table_busy(tbusy), .i_move_instr(mv), .i_in_repeat(rep), .i_rpt_first(fl[0]),
    .i_rpt_last(fl[1]), .i_rpt_irq_exit(fl[2]), .i_rpt_irq_reentry(fl[3]),
    .i_prog_word(word), .o_ready(ready), .o_stall(stall), .o_ram_req(ram_req),
    .o_ram_addr(ram_addr), .o_prog_req(prog_req), .o_prog_addr(prog_addr),
    .o_rd_valid(rd_valid), .o_rd_data(rd_data));
  pswin_prog_mem_model mem (.i_sys_clk(i_sys_clk), .i_prog_req(prog_req),
    .i_prog_addr(prog_addr), .o_prog_word(word));
  // ==========================================================
  // Checking and closing
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic summarize;
    $display("Counts: compares=%0d errors=%0d", compares, errors);
    if (errors == 0 && compares > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : summarize
  // ==========================================================
  // One read, requested for one cycle while ready, then followed for at most eight cycles
  task automatic access(input logic [15:0] a, input logic e, input logic t, input logic m,
                        input logic r, input logic [3:0] f, input logic [7:0] p);
    int n, k, st, lat;
    logic win;
    win = (a >= WIN_BASE) & e & !t;
    n = !r ? (m ? 1 : 2) : (|f ? 2 : 0);
    st = 0;
    lat = 0;
    if (win) exp_q.push_back({p[0], a[14:0]} ^ 16'hA5C3);
    chk(ready, 1'b1);
    ea = a; en = e; tbusy = t; mv = m; rep = r; fl = f; page = p; req = 1'b1;
    @(negedge i_sys_clk);
    req = 1'b0;
    for (k = 1; k <= 8 && lat == 0; k++) begin
      if (k == 1 && win) chk({prog_req, 8'h00, prog_addr}, {1'b1, 8'h00, p, a[14:0]});
      st += stall;
      if ((win && rd_valid === 1'b1) || (!win && ram_req === 1'b1)) lat = k;
      @(negedge i_sys_clk);
    end
    if (lat == 0) begin
      errors++;
      summarize();
    end else if (win) begin
      chk(lat, 2 + n);
      chk(st, n);
      chk(rd_data, exp_q.pop_front());
    end else begin
      chk(lat, 32'd1);
      chk(st, 32'd0);
      chk(ram_addr, a);
    end
  endtask : access
  initial begin
    forever #25 i_sys_clk = ~i_sys_clk;
  end
  initial begin : main
    int i;
    logic [31:0] r1, r2;
    repeat (3) @(negedge i_sys_clk);
    chk({ready, stall, ram_req, prog_req, rd_valid}, 5'b10000);
    i_sys_rst = 1'b0;
    @(negedge i_sys_clk);
    for (i = 0; i < 4; i++) access(16'hFFFF, 1'b1, 1'b0, 1'b0, 1'b1, 4'h1 << i, 8'hFF);
    access(16'h8000, 1'b1, 1'b0, 1'b1, 1'b1, 4'h0, 8'h00);
    $display("Test repeat loop done");
    access(16'h8001, 1'b1, 1'b0, 1'b1, 1'b0, 4'h0, 8'hA5);
    access(16'hC000, 1'b1, 1'b0, 1'b0, 1'b0, 4'h0, 8'h5A);
    access(16'hC000, 1'b1, 1'b1, 1'b0, 1'b0, 4'h0, 8'h5A);
    access(16'hC000, 1'b0, 1'b0, 1'b0, 1'b0, 4'h0, 8'h5A);
    access(16'h7FFF, 1'b1, 1'b0, 1'b0, 1'b0, 4'h0, 8'h5A);
    $display("Test directed classes done");
    for (i = 0; i < 60; i++) begin
      r1 = $random(seed);
      r2 = $random(seed);
      access(r1[15:0], r2[0], r2[1] & r2[2], r2[3], r2[4], r2[8:5], r1[23:16]);
    end
    $display("Test random accesses done");
    summarize();
  end
endmodule : tb
`default_nettype wire
